/* hdl/reset_cause_and_low_voltage_flags.sv */
`timescale 1ns/1ps
`include "reset_seq_params.svh"
// How it works
// (R1) any reset source holds core in reset, registers initialised, pc cleared; code updates cause, mode, flags; ctrl/event/mask reset only by rst_i
// (R2) after release the core fetches from program address zero
// (R3) cause held in status bits 7:6: 00 watchdog, 10 power, 11 pin
// (R4) cause bits sit in status register at 0x86, software read/write
// (R5) sequence: stable supply, pin check, init, warm-up, then run
// (R6) with pin enabled, stay in reset while pin is not high
// (R7) watchdog overflow resets, then init, warm-up and run
// (R8) after watchdog reset the core restarts in normal mode
// (R9) supply below selected threshold forces reset
// (R10) three detector levels; lowest level always resets
// (R11) low option: reset below lowest level, both flags disabled
// (R12) mid option: reset below lowest level, only 2.4 V flag enabled
// (R13) high option: reset below 2.4 V, both flags enabled
// (R14) max option: reset below 3.6 V, both flags disabled
// (R15) bit 4 reads 1 while supply at or below 2.4 V
// (R16) bit 5 reads 1 while supply at or below 3.6 V
// (R17) a low-voltage reset clears both indicator flags
// (R18) pin resets only when the pin option selects reset function
// (R19) reserved cause never set by hardware, software write can store it; async inputs synchronised first
module reset_cause_and_low_voltage_flags #(
	parameter int SETTLE_CYCLES = (`SUPPLY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int WARMUP_CYCLES = (`WARMUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int CNT_W = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [1:0] detect_option_i,
	input wire logic pin_reset_enable_i,
	input wire logic reset_pin_i,
	input wire logic below_2v0_i,
	input wire logic below_2v4_i,
	input wire logic below_3v6_i,
	input wire logic wdog_overflow_i,
	output logic core_reset_o,
	output logic [9:0] pc_start_o,
	output logic normal_mode_o,
	output logic irq_o
);
	localparam logic [CNT_W-1:0] SETTLE_N = CNT_W'(SETTLE_CYCLES);
	localparam logic [CNT_W-1:0] WARM_N = CNT_W'(WARMUP_CYCLES);
	localparam logic [CNT_W-1:0] INIT_N = CNT_W'(`INIT_CYCLES);
	localparam logic [7:0] MASK_INIT = `MASK_RESET;
	// pin idles high, comparators idle low
	localparam logic [3:0] SYNC_IDLE = 4'h8;

	// synchroniser inputs and outputs
	logic [3:0] async_in;
	logic [3:0] sync_s;
	logic pin_s;
	logic b20_s;
	logic b24_s;
	logic b36_s;

	// sequencer
	reset_seq_pkg::seq_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic settle_done;
	logic init_done;
	logic warm_done;

	// registers
	logic [1:0] cause_q;
	logic [1:0] cause_d;
	logic [7:0] ctrl_q;
	logic [2:0] evt_q;
	logic [2:0] mask_q;
	logic irq_d;

	// reset sources
	logic lv_reset;
	logic pin_reset;
	logic any_reset;

	// indicator flags, bit 0 is 2.4 V, bit 1 is 3.6 V
	logic [1:0] flag_en;
	logic [1:0] flag_lvl;
	logic [1:0] flag_s;

	// bus decode
	logic acc;
	logic wr;
	logic hit_status;
	logic hit_ctrl;
	logic hit_evt;
	logic hit_mask;
	logic hit_any;
	logic status_wr;
	logic ctrl_wr;
	logic evt_wr;
	logic mask_wr;
	logic [2:0] evt_set;

	// two-stage synchronisers, one per input, reset to idle level [R19]
	assign async_in = {reset_pin_i, below_2v0_i, below_2v4_i, below_3v6_i};
	for (genvar i = 0; i < 4; i++) begin : g_sync
		logic stage1_q;
		logic stage2_q;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				stage1_q <= SYNC_IDLE[i];
				stage2_q <= SYNC_IDLE[i];
			end else if (ce_i) begin
				stage1_q <= async_in[i];
				stage2_q <= stage1_q;
			end
		end
		assign sync_s[i] = stage2_q;
	end
	assign pin_s = sync_s[3];
	assign b20_s = sync_s[2];
	assign b24_s = sync_s[1];
	assign b36_s = sync_s[0];

	// threshold per option [R9] [R10] [R11] [R12] [R13] [R14]
	always_comb begin
		case (detect_option_i)
			`OPT_LOW: lv_reset = b20_s;
			`OPT_MID: lv_reset = b20_s;
			`OPT_HIGH: lv_reset = b20_s | b24_s;
			`OPT_MAX: lv_reset = b20_s | b24_s | b36_s;
			default: lv_reset = b20_s;
		endcase
	end

	// flag enables per option, bit 0 the 2.4 V flag [R11] [R12] [R13] [R14]
	always_comb begin
		case (detect_option_i)
			`OPT_LOW: flag_en = 2'h0;
			`OPT_MID: flag_en = 2'h1;
			`OPT_HIGH: flag_en = 2'h3;
			`OPT_MAX: flag_en = 2'h0;
			default: flag_en = 2'h0;
		endcase
	end

	// terminal counts of the sequencer phases
	assign settle_done = (cnt_q >= SETTLE_N - 1'b1);
	assign init_done = (cnt_q >= INIT_N - 1'b1);
	assign warm_done = (cnt_q >= WARM_N - 1'b1);
	assign pin_reset = pin_reset_enable_i && !pin_s; // [R6] [R18]
	assign any_reset = lv_reset | pin_reset | wdog_overflow_i; // [R1]

	// reset sequencer [R5]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= reset_seq_pkg::ST_SUPPLY;
			cnt_q <= '0;
		end else if (ce_i) begin
			if (lv_reset) begin
				state_q <= reset_seq_pkg::ST_SUPPLY; // [R9]
				cnt_q <= '0;
			end else if (pin_reset) begin
				state_q <= reset_seq_pkg::ST_PIN; // [R6]
				cnt_q <= '0;
			end else if (wdog_overflow_i) begin
				state_q <= reset_seq_pkg::ST_INIT; // [R7]
				cnt_q <= '0;
			end else begin
				case (state_q)
					reset_seq_pkg::ST_SUPPLY: begin
						if (settle_done) begin
							state_q <= reset_seq_pkg::ST_PIN;
							cnt_q <= '0;
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
					reset_seq_pkg::ST_PIN: begin
						state_q <= reset_seq_pkg::ST_INIT; // [R6]
						cnt_q <= '0;
					end
					reset_seq_pkg::ST_INIT: begin
						if (init_done) begin
							state_q <= reset_seq_pkg::ST_WARM;
							cnt_q <= '0;
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
					reset_seq_pkg::ST_WARM: begin
						if (warm_done) begin
							state_q <= reset_seq_pkg::ST_RUN;
							cnt_q <= '0;
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
					reset_seq_pkg::ST_RUN: state_q <= reset_seq_pkg::ST_RUN;
					default: state_q <= reset_seq_pkg::ST_SUPPLY;
				endcase
			end
		end
	end

	// core held in reset until the sequence reaches run [R1]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b1;
		end else if (ce_i) begin
			core_reset_o <= any_reset || (state_q != reset_seq_pkg::ST_RUN); // [R1]
		end
	end

	// program start address is always zero [R2]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_start_o <= 10'h000;
		end else if (ce_i) begin
			pc_start_o <= 10'h000; // [R2]
		end
	end

	// any reset returns the core to normal mode [R8]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			normal_mode_o <= 1'b1;
		end else if (ce_i) begin
			if (any_reset) begin
				normal_mode_o <= 1'b1; // [R8]
			end else if (ctrl_wr) begin
				normal_mode_o <= ~wb_dat_i[0];
			end
		end
	end

	// bus decode, one access per request
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit_status = (wb_adr_i == `ADDR_STATUS);
	assign hit_ctrl = (wb_adr_i == `ADDR_CTRL);
	assign hit_evt = (wb_adr_i == `ADDR_EVT);
	assign hit_mask = (wb_adr_i == `ADDR_MASK);
	assign hit_any = hit_status || hit_ctrl || hit_evt || hit_mask;
	assign wr = acc && wb_we_i && hit_any;
	assign status_wr = wr && hit_status && wb_sel_i[0];
	assign ctrl_wr = wr && hit_ctrl && wb_sel_i[0];
	assign evt_wr = wr && hit_evt && wb_sel_i[0];
	assign mask_wr = wr && hit_mask && wb_sel_i[0];

	// reset cause next value, hardware wins over software [R3] [R4] [R19]
	always_comb begin
		cause_d = cause_q;
		if (lv_reset) begin
			cause_d = `CAUSE_POWER;
		end else if (pin_reset) begin
			cause_d = `CAUSE_PIN;
		end else if (wdog_overflow_i) begin
			cause_d = `CAUSE_WDOG;
		end else if (status_wr) begin
			cause_d = wb_dat_i[`BIT_CAUSE_HI:`BIT_CAUSE_LO];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_q <= `CAUSE_POWER;
		end else if (ce_i) begin
			cause_q <= cause_d;
		end
	end

	// low-voltage indicator flags, live levels gated by option [R15] [R16] [R17]
	assign flag_lvl = {b36_s, b24_s};
	for (genvar f = 0; f < 2; f++) begin : g_flag
		logic flag_q;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				flag_q <= 1'b0;
			end else if (ce_i) begin
				if (lv_reset) begin
					flag_q <= 1'b0; // [R17]
				end else begin
					flag_q <= flag_en[f] && flag_lvl[f]; // [R15] [R16]
				end
			end
		end
		assign flag_s[f] = flag_q;
	end

	// control register, spare software bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `CTRL_RESET;
		end else if (ce_i && ctrl_wr) begin
			ctrl_q <= wb_dat_i[7:0];
		end
	end

	// events: 0 low voltage, 1 pin, 2 watchdog; set wins over clear
	assign evt_set = {wdog_overflow_i, pin_reset, lv_reset};
	for (genvar e = 0; e < 3; e++) begin : g_evt
		logic evt_bit_q;
		logic mask_bit_q;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				evt_bit_q <= 1'b0;
			end else if (ce_i) begin
				if (evt_set[e]) begin
					evt_bit_q <= 1'b1;
				end else if (evt_wr && wb_dat_i[e]) begin
					evt_bit_q <= 1'b0;
				end
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mask_bit_q <= MASK_INIT[e];
			end else if (ce_i && mask_wr) begin
				mask_bit_q <= wb_dat_i[e];
			end
		end
		assign evt_q[e] = evt_bit_q;
		assign mask_q[e] = mask_bit_q;
	end

	// level interrupt, one cycle behind the event and mask bits
	assign irq_d = |(evt_q & mask_q);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= irq_d;
		end
	end

	// wishbone slave, one wait state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			if (acc) begin
				case (wb_adr_i)
					`ADDR_STATUS: begin
						wb_ack_o <= 1'b1;
						wb_dat_o <= {24'h000000, cause_q, flag_s[1], flag_s[0], 4'h0};
					end
					`ADDR_CTRL: begin
						wb_ack_o <= 1'b1;
						wb_dat_o <= {24'h000000, ctrl_q[7:1], ~normal_mode_o};
					end
					`ADDR_EVT: begin
						wb_ack_o <= 1'b1;
						wb_dat_o <= {29'h0, evt_q};
					end
					`ADDR_MASK: begin
						wb_ack_o <= 1'b1;
						wb_dat_o <= {29'h0, mask_q};
					end
					default: begin
						wb_err_o <= 1'b1;
						wb_dat_o <= 32'h0000_0000;
					end
				endcase
			end
		end
	end
endmodule // reset_cause_and_low_voltage_flags

/* hdl/reset_seq_params.svh */
`ifndef RESET_SEQ_PARAMS_SVH
`define RESET_SEQ_PARAMS_SVH
// register byte addresses
`define ADDR_STATUS 8'h86
`define ADDR_CTRL 8'h88
`define ADDR_EVT 8'h8c
`define ADDR_MASK 8'h90
// status field positions
`define BIT_CAUSE_HI 7
`define BIT_CAUSE_LO 6
`define BIT_FLAG_3V6 5
`define BIT_FLAG_2V4 4
// cause encodings
`define CAUSE_WDOG 2'h0
`define CAUSE_RSVD 2'h1
`define CAUSE_POWER 2'h2
`define CAUSE_PIN 2'h3
// detector options
`define OPT_LOW 2'h0
`define OPT_MID 2'h1
`define OPT_HIGH 2'h2
`define OPT_MAX 2'h3
// reset values
`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00
// timing
`define SUPPLY_SETTLE_NS 800
`define INIT_CYCLES 4
`define WARMUP_NS 8000
`define CLK_PERIOD_NS 8
`endif

/* hdl/reset_seq_pkg.sv */
package reset_seq_pkg;
	typedef enum logic [2:0] {
		ST_SUPPLY,
		ST_PIN,
		ST_INIT,
		ST_WARM,
		ST_RUN
	} seq_state_t;
endpackage

/* verification/reset_flags_monitor.sv */
`timescale 1ns/1ps
module reset_flags_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic pin_reset_enable_i,
	input wire logic reset_pin_i,
	input wire logic below_2v0_i,
	input wire logic wdog_overflow_i,
	input wire logic core_reset_o,
	input wire logic [9:0] pc_start_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_pc; pc_start_o == 10'h000; endproperty
	a_pc: assert property (p_pc) else $error("pc not zero");
	property p_wd; wdog_overflow_i |=> core_reset_o; endproperty
	a_wd: assert property (p_wd) else $error("no wdog reset");
	property p_lv; below_2v0_i [*5] |-> core_reset_o; endproperty
	a_lv: assert property (p_lv) else $error("no low volt reset");
	property p_pin; (pin_reset_enable_i && !reset_pin_i) [*5] |-> core_reset_o; endproperty
	a_pin: assert property (p_pin) else $error("no pin reset");
	property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack too long");
	property p_rsp; wb_cyc_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o; endproperty
	a_rsp: assert property (p_rsp) else $error("no answer");
	property p_err; wb_err_o |-> wb_dat_o == 32'h0; endproperty
	a_err: assert property (p_err) else $error("err data");
	property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper data");
endmodule // reset_flags_monitor
bind reset_cause_and_low_voltage_flags reset_flags_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i,
	.wb_dat_o, .wb_ack_o, .wb_err_o, .pin_reset_enable_i, .reset_pin_i, .below_2v0_i,
	.wdog_overflow_i, .core_reset_o, .pc_start_o);

/* verification/supply_pin_model.sv */
`timescale 1ns/1ps
module supply_pin_model (
	input wire logic [11:0] vdd_mv_i,
	input wire logic hold_pin_i,
	output logic reset_pin_o,
	output logic below_2v0_o,
	output logic below_2v4_o,
	output logic below_3v6_o
);
	assign reset_pin_o = !hold_pin_i;
	assign below_2v0_o = vdd_mv_i < 12'h7d0;
	assign below_2v4_o = vdd_mv_i <= 12'h960;
	assign below_3v6_o = vdd_mv_i <= 12'he10;
endmodule // supply_pin_model

/* verification/test_reset_cause_and_low_voltage_flags.sv */
`timescale 1ns/1ps
module test_reset_cause_and_low_voltage_flags;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, wdog = 0, pen = 0, hold = 0;
	logic ev, ack, err, core, nm, irq, b20, b24, b36, pin;
	logic [1:0] opt = 2'h0;
	logic [7:0] adr = 8'h00;
	logic [9:0] pc;
	logic [11:0] vdd = 12'hce4;
	logic [31:0] wd = 32'h0, rd, rv;
	logic [27:0] tab [5] = '{28'h0898000, 28'h1960100, 28'h2bb8200, 28'h3bb8001, 28'h28fc001};
	int mismatches = 0, cmp_count = 0;
	always #4 clk_i = ~clk_i;
	supply_pin_model u_pm (.vdd_mv_i(vdd), .hold_pin_i(hold), .reset_pin_o(pin),
		.below_2v0_o(b20), .below_2v4_o(b24), .below_3v6_o(b36));
	reset_cause_and_low_voltage_flags #(.SETTLE_CYCLES(3), .WARMUP_CYCLES(5)) u_dut (
		.clk_i, .rst_i, .ce_i(1'b1), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
		.wb_err_o(err), .detect_option_i(opt), .pin_reset_enable_i(pen), .reset_pin_i(pin),
		.below_2v0_i(b20), .below_2v4_i(b24), .below_3v6_i(b36), .wdog_overflow_i(wdog),
		.core_reset_o(core), .pc_start_o(pc), .normal_mode_o(nm), .irq_o(irq));
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		adr <= a;
		we <= w;
		wd <= d;
		cyc <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
		rv = rd;
		ev = err;
		cyc <= 1'b0;
		if (k == 50) begin
			mismatches++;
			stop_test();
		end
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] x);
		bus(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), {24'h0, x}, rv);
	endtask
	task automatic run;
		for (int k = 0; k < 60 && core !== 1'b0; k++) @(posedge clk_i);
		chk("run", 32'h0, 32'(core));
		if (core !== 1'b0) stop_test();
	endtask
	task automatic reset(input logic [1:0] o, input logic [11:0] v);
		rst_i <= 1'b1;
		opt <= o;
		vdd <= v;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	initial begin
		reset(2'h0, 12'hce4);
		chk("core", 32'h1, 32'(core));
		run();
		chk("pc", 32'h0, 32'(pc));
		rdc(8'h86, 8'h80);
		bus(8'h86, 1'b1, 32'hf0);
		rdc(8'h86, 8'hc0);
		rdc(8'h84, 8'h00);
		chk("err", 32'h1, 32'(ev));
		for (int i = 0; i < 5; i++) begin
			reset(tab[i][25:24], tab[i][23:12]);
			repeat (40) @(posedge clk_i);
			chk("core", 32'(tab[i][0]), 32'(core));
			rdc(8'h86, 8'h80 | tab[i][11:4]);
		end
		reset(2'h0, 12'hce4);
		run();
		bus(8'h88, 1'b1, 32'h1);
		chk("normal", 32'h0, 32'(nm));
		wdog <= 1'b1;
		@(posedge clk_i);
		wdog <= 1'b0;
		@(posedge clk_i);
		chk("core", 32'h1, 32'(core));
		rdc(8'h86, 8'h00);
		run();
		chk("normal", 32'h1, 32'(nm));
		bus(8'h90, 1'b1, 32'h0);
		chk("irq", 32'h0, 32'(irq));
		bus(8'h90, 1'b1, 32'h4);
		chk("irq", 32'h1, 32'(irq));
		bus(8'h8c, 1'b1, 32'h4);
		chk("irq", 32'h0, 32'(irq));
		hold <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk("core", 32'h0, 32'(core));
		pen <= 1'b1;
		reset(2'h0, 12'hce4);
		repeat (40) @(posedge clk_i);
		chk("core", 32'h1, 32'(core));
		hold <= 1'b0;
		run();
		hold <= 1'b1;
		repeat (6) @(posedge clk_i);
		rdc(8'h86, 8'hc0);
		stop_test();
	end
endmodule // test_reset_cause_and_low_voltage_flags
